// ---- pkg/monitor_regs_pkg.sv ----
// constants shared by the monitor readback bank: register indices, field
// positions and reset values.
// assumes an apb slave with 32-bit data; byte address = 4 * register index.
package monitor_regs_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned INDEX_W = 14;
  localparam int unsigned NUM_MON = 8;
  localparam int unsigned COUNT_W = 16;

  // ------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [INDEX_W-1:0] COMMUTATION_COSINE_IDX      = 14'h04b8;
  localparam logic [INDEX_W-1:0] ALPHA_AXIS_CURRENT_IDX      = 14'h04d2;
  localparam logic [INDEX_W-1:0] BETA_AXIS_CURRENT_IDX       = 14'h04d4;
  localparam logic [INDEX_W-1:0] ALPHA_AXIS_VOLTAGE_IDX      = 14'h04d6;
  localparam logic [INDEX_W-1:0] BETA_AXIS_VOLTAGE_IDX       = 14'h04d8;
  localparam logic [INDEX_W-1:0] DIRECT_AXIS_CURRENT_IDX     = 14'h04e2;
  localparam logic [INDEX_W-1:0] QUADRATURE_AXIS_CURRENT_IDX = 14'h04e4;
  localparam logic [INDEX_W-1:0] DIRECT_AXIS_VOLTAGE_IDX     = 14'h04e6;
  localparam logic [INDEX_W-1:0] MONITOR_CONTROL_IDX         = 14'h04f0;
  localparam logic [INDEX_W-1:0] MONITOR_STATUS_IDX          = 14'h04f2;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned CTRL_FREEZE_BIT   = 0;
  localparam int unsigned STAT_COUNT_LSB    = 0;
  localparam int unsigned STAT_FREEZE_BIT   = 16;
  localparam int unsigned STAT_MISSED_BIT   = 17;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [DATA_W-1:0]  MONITOR_RESET = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0]  UNMAPPED_READ = 32'h0000_0000;

  // ------------------------------------------------------------------
  // bus phase of the slave
  // ------------------------------------------------------------------
  typedef enum logic [0:0] {
    PHASE_IDLE   = 1'b0,
    PHASE_ANSWER = 1'b1
  } phase_e;

endpackage

// ---- src/monitor_slot.sv ----
// one 32-bit read-only monitor word, loaded from the control algorithm.
// assumes load is a single-cycle strobe synchronous to clk.
`timescale 1ns/10ps
module monitor_slot
  import monitor_regs_pkg::*;
(
  input  wire logic              clk,    // system clock
  input  wire logic              resetn, // async reset, active low
  input  wire logic              load,   // take din this cycle
  input  wire logic [DATA_W-1:0] din,    // freshly computed value
  output logic      [DATA_W-1:0] dout    // held value seen by software
);

  typedef struct packed {
    logic [DATA_W-1:0] word;
  } slot_s;

  slot_s state;
  slot_s next_state;

  always_comb begin
    next_state = state;
    if (load) begin
      next_state.word = din;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{word: MONITOR_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign dout = state.word;

endmodule

// ---- src/foc_monitor_readback_regs.sv ----
// read-only bank of fixed-point monitor words of the motor control loop,
// reached over apb.
// assumes the control algorithm presents all eight values together and
// pulses update for one cycle when a control update is complete.
//
// What this block does
// RULE1 - The angle cosine is readable at index 4b8h as a 32-bit word scaled by 2^27.
// RULE2 - The alpha current is readable at index 4d2h, scaled by 2^27 and full scale over 8.
// RULE3 - The beta current is readable at index 4d4h with the same scaling as alpha current.
// RULE4 - The alpha voltage is readable at index 4d6h, scaled by 2^27, times 60 over root 3.
// RULE5 - The beta voltage is readable at index 4d8h with the same voltage scaling.
// RULE6 - The estimated d-axis current is readable at index 4e2h with current scaling.
// RULE7 - The estimated q-axis current is readable at index 4e4h with current scaling.
// RULE8 - The applied d-axis voltage is readable at index 4e6h with voltage scaling.
// RULE9 - Every monitor word resets to zero and software writes never change it.
// RULE10 - Each word is refreshed once per control update and a read returns a whole coherent word; the code drops updates while freeze is set.
`timescale 1ns/10ps
module foc_monitor_readback_regs
  import monitor_regs_pkg::*;
(
  input  wire logic              clk,                     // 10 mhz system clock
  input  wire logic              resetn,                  // async reset, active low
  // apb slave
  input  wire logic              psel,                    // slave select
  input  wire logic              penable,                 // access phase
  input  wire logic              pwrite,                  // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] paddr,                   // byte address
  input  wire logic [DATA_W-1:0] pwdata,                  // write data
  output logic      [DATA_W-1:0] prdata,                  // read data
  output logic                   pready,                  // transfer done
  output logic                   pslverr,                 // write to ro or unmapped
  // control algorithm side
  input  wire logic              update,                  // one-cycle refresh strobe
  input  wire logic [DATA_W-1:0] commutation_cosine,      // cos of angle
  input  wire logic [DATA_W-1:0] alpha_axis_current,      // alpha current
  input  wire logic [DATA_W-1:0] beta_axis_current,       // beta current
  input  wire logic [DATA_W-1:0] alpha_axis_voltage,      // alpha voltage
  input  wire logic [DATA_W-1:0] beta_axis_voltage,       // beta voltage
  input  wire logic [DATA_W-1:0] direct_axis_current,     // estimated d current
  input  wire logic [DATA_W-1:0] quadrature_axis_current, // estimated q current
  input  wire logic [DATA_W-1:0] direct_axis_voltage,     // applied d voltage
  output logic                   frozen                   // snapshot held by software
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    phase_e             phase;
    logic [DATA_W-1:0]  rdata;
    logic               ready;
    logic               slverr;
    logic               freeze;
    logic [COUNT_W-1:0] update_count;
    logic               missed;
  } bank_s;

  bank_s state;
  bank_s next_state;

  logic [DATA_W-1:0]  mon_in  [NUM_MON];
  logic [DATA_W-1:0]  mon_out [NUM_MON];
  logic               take_update;
  logic [INDEX_W-1:0] index;
  logic               aligned;
  logic               setup;
  logic               done;
  logic               ctrl_write;
  logic               stat_write;

  // ------------------------------------------------------------------
  // monitor words
  // ------------------------------------------------------------------
  assign mon_in[0] = commutation_cosine;      // [RULE1]
  assign mon_in[1] = alpha_axis_current;      // [RULE2]
  assign mon_in[2] = beta_axis_current;       // [RULE3]
  assign mon_in[3] = alpha_axis_voltage;      // [RULE4]
  assign mon_in[4] = beta_axis_voltage;       // [RULE5]
  assign mon_in[5] = direct_axis_current;     // [RULE6]
  assign mon_in[6] = quadrature_axis_current; // [RULE7]
  assign mon_in[7] = direct_axis_voltage;     // [RULE8]

  // all eight load on the same edge so a set of reads sees one update
  assign take_update = update && !state.freeze; // [RULE10]

  generate
    for (genvar i = 0; i < NUM_MON; i++) begin : g_slot
      monitor_slot u_slot (
        .clk    (clk),
        .resetn (resetn),
        .load   (take_update),
        .din    (mon_in[i]),
        .dout   (mon_out[i])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  assign index      = paddr[ADDR_W-1:2];
  assign aligned    = (paddr[1:0] == 2'h0);
  assign setup      = psel && !penable;
  assign done       = psel && penable && state.ready;
  assign ctrl_write = done && pwrite && aligned && (index == MONITOR_CONTROL_IDX);
  assign stat_write = done && pwrite && aligned && (index == MONITOR_STATUS_IDX);

  // read value of one word; whole word is latched at once into prdata
  function automatic logic [DATA_W-1:0] read_word(
    input logic [INDEX_W-1:0] idx,
    input bank_s              st
  );
    logic [DATA_W-1:0] word;
    word = UNMAPPED_READ;
    case (idx)
      COMMUTATION_COSINE_IDX:      word = mon_out[0]; // [RULE1]
      ALPHA_AXIS_CURRENT_IDX:      word = mon_out[1]; // [RULE2]
      BETA_AXIS_CURRENT_IDX:       word = mon_out[2]; // [RULE3]
      ALPHA_AXIS_VOLTAGE_IDX:      word = mon_out[3]; // [RULE4]
      BETA_AXIS_VOLTAGE_IDX:       word = mon_out[4]; // [RULE5]
      DIRECT_AXIS_CURRENT_IDX:     word = mon_out[5]; // [RULE6]
      QUADRATURE_AXIS_CURRENT_IDX: word = mon_out[6]; // [RULE7]
      DIRECT_AXIS_VOLTAGE_IDX:     word = mon_out[7]; // [RULE8]
      MONITOR_CONTROL_IDX: begin
        word[CTRL_FREEZE_BIT] = st.freeze;
      end
      MONITOR_STATUS_IDX: begin
        word[STAT_COUNT_LSB +: COUNT_W] = st.update_count;
        word[STAT_FREEZE_BIT]           = st.freeze;
        word[STAT_MISSED_BIT]           = st.missed;
      end
      default: word = UNMAPPED_READ;
    endcase
    return word;
  endfunction

  // error answer: any misaligned access, any write outside the control and
  // status words, or any access to an index that holds nothing
  function automatic logic access_error(
    input logic [INDEX_W-1:0] idx,
    input logic               ok_align,
    input logic               wr
  );
    logic err;
    err = 1'b0;
    if (!ok_align) begin
      err = 1'b1;
    end else begin
      case (idx)
        COMMUTATION_COSINE_IDX,
        ALPHA_AXIS_CURRENT_IDX,
        BETA_AXIS_CURRENT_IDX,
        ALPHA_AXIS_VOLTAGE_IDX,
        BETA_AXIS_VOLTAGE_IDX,
        DIRECT_AXIS_CURRENT_IDX,
        QUADRATURE_AXIS_CURRENT_IDX,
        DIRECT_AXIS_VOLTAGE_IDX: err = wr; // [RULE9]
        MONITOR_CONTROL_IDX,
        MONITOR_STATUS_IDX:      err = 1'b0;
        default:                 err = 1'b1;
      endcase
    end
    return err;
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;

    // bus answer: pready rises in the first access cycle
    case (state.phase)
      PHASE_IDLE: begin
        next_state.ready  = 1'b0;
        next_state.slverr = 1'b0;
        if (setup) begin
          next_state.phase  = PHASE_ANSWER;
          next_state.ready  = 1'b1;
          next_state.slverr = access_error(index, aligned, pwrite);
          // a misaligned read is refused and must not leak a monitor word
          if (!pwrite && aligned) begin
            next_state.rdata = read_word(index, state); // [RULE10]
          end
        end
      end
      PHASE_ANSWER: begin
        if (done) begin
          next_state.ready  = 1'b0;
          next_state.slverr = 1'b0;
          next_state.rdata  = UNMAPPED_READ;
          next_state.phase  = PHASE_IDLE;
        end
      end
      default: begin
        next_state.phase = PHASE_IDLE;
        next_state.ready = 1'b0;
      end
    endcase

    // control word: monitor words themselves have no write path
    if (ctrl_write) begin
      next_state.freeze = pwdata[CTRL_FREEZE_BIT]; // [RULE9]
    end

    // status: count of updates taken, sticky flag for updates dropped
    if (take_update) begin
      next_state.update_count = state.update_count + COUNT_W'(1); // [RULE10]
    end
    if (stat_write && pwdata[STAT_MISSED_BIT]) begin
      next_state.missed = 1'b0;
    end
    // a dropped update in the clearing cycle still sets the flag
    if (update && state.freeze) begin
      next_state.missed = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{phase:        PHASE_IDLE,
                 rdata:        UNMAPPED_READ,
                 ready:        1'b0,
                 slverr:       1'b0,
                 freeze:       1'b0,
                 update_count: COUNT_RESET,
                 missed:       1'b0}; // [RULE9]
    end else begin
      state <= next_state;
    end
  end

  assign prdata  = state.rdata;
  assign pready  = state.ready;
  assign pslverr = state.slverr;
  assign frozen  = state.freeze;

endmodule

// ---- verif/foc_monitor_checker_assertions.sv ----
// assertions on the apb side and refresh path of the monitor bank.
// assumes one clock domain; bound to the bank's top module below.
`timescale 1ns/10ps
module foc_monitor_checker
  import monitor_regs_pkg::*;
(
  input wire logic              clk,               // clock
  input wire logic              resetn,            // reset, active low
  input wire logic              psel,              // select
  input wire logic              penable,           // access phase
  input wire logic              pwrite,            // direction
  input wire logic [ADDR_W-1:0] paddr,             // byte address
  input wire logic [DATA_W-1:0] pwdata,            // write data
  input wire logic [DATA_W-1:0] prdata,            // read data
  input wire logic              pready,            // done
  input wire logic              pslverr,           // refused
  input wire logic              update,            // refresh strobe
  input wire logic              frozen,            // snapshot held
  input wire logic [DATA_W-1:0] commutation_cosine // cosine input
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  function automatic logic is_mon(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'b00 && a[15:2] inside {COMMUTATION_COSINE_IDX,
      ALPHA_AXIS_CURRENT_IDX, BETA_AXIS_CURRENT_IDX, ALPHA_AXIS_VOLTAGE_IDX,
      BETA_AXIS_VOLTAGE_IDX, DIRECT_AXIS_CURRENT_IDX, QUADRATURE_AXIS_CURRENT_IDX,
      DIRECT_AXIS_VOLTAGE_IDX};
  endfunction

  function automatic logic is_bad(input logic [ADDR_W-1:0] a);
    return !is_mon(a) && !(a[1:0] == 2'b00 &&
      a[15:2] inside {MONITOR_CONTROL_IDX, MONITOR_STATUS_IDX});
  endfunction

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_update_taken;
    update && !frozen;
  endsequence
  sequence s_ctrl_write;
    psel && penable && pready && pwrite && paddr == {MONITOR_CONTROL_IDX, 2'b00};
  endsequence
  sequence s_cos_read;
    psel && !penable && !pwrite && paddr == {COMMUTATION_COSINE_IDX, 2'b00};
  endsequence

  a_ready_next: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("answer without setup");
  a_idle_zero: assert property (!pready |-> prdata == '0)
    else $error("read data not zero outside a transfer");
  a_ro_write_err: assert property (s_setup ##0 (pwrite && is_mon(paddr)) |=> pslverr)
    else $error("monitor word write not refused");
  a_mon_read_ok: assert property (s_setup ##0 (!pwrite && is_mon(paddr)) |=> !pslverr)
    else $error("monitor word read refused");
  a_bad_addr_err: assert property (s_setup ##0 is_bad(paddr) |=> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  a_cos_fresh: assert property (s_update_taken ##1 s_cos_read
    |=> prdata == $past(commutation_cosine, 2))
    else $error("cosine read not the last taken value");
  a_reset_quiet: assert property ($rose(resetn) |-> !pready && !frozen && prdata == '0)
    else $error("outputs not idle after reset");
  a_freeze_follow: assert property (s_ctrl_write |=> frozen == $past(pwdata[CTRL_FREEZE_BIT]))
    else $error("frozen pin does not follow control write");
endmodule

bind foc_monitor_readback_regs foc_monitor_checker chk_inst (.clk, .resetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .update, .frozen,
  .commutation_cosine);

// ---- verif/testbench.sv ----
// self-checking bench for the monitor readback bank over apb.
// assumes the checker binds itself to the bank from its own file.
`timescale 1ns/10ps
module testbench;
  import monitor_regs_pkg::*;

  localparam logic [INDEX_W-1:0] IDX [8] = '{COMMUTATION_COSINE_IDX,
    ALPHA_AXIS_CURRENT_IDX, BETA_AXIS_CURRENT_IDX, ALPHA_AXIS_VOLTAGE_IDX,
    BETA_AXIS_VOLTAGE_IDX, DIRECT_AXIS_CURRENT_IDX, QUADRATURE_AXIS_CURRENT_IDX,
    DIRECT_AXIS_VOLTAGE_IDX};
  logic              clk, resetn, psel, penable, pwrite, update, pready, pslverr, frozen;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [DATA_W-1:0] vin [8];
  logic [DATA_W-1:0] mon [8];
  logic [DATA_W:0]   exp_q [$];
  logic [DATA_W:0]   got, want;
  int                num_errors = 0;
  int                checked = 0;

  foc_monitor_readback_regs foc_monitor_readback_regs_inst (
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .update, .commutation_cosine(vin[0]), .alpha_axis_current(vin[1]),
    .beta_axis_current(vin[2]), .alpha_axis_voltage(vin[3]), .beta_axis_voltage(vin[4]),
    .direct_axis_current(vin[5]), .quadrature_axis_current(vin[6]),
    .direct_axis_voltage(vin[7]), .frozen);

  task automatic finish_test();
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----
  // bus and update drivers; e is the expected {pslverr, prdata}
  // ----
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [DATA_W:0] e);
    exp_q.push_back(e);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_all();
    foreach (IDX[i]) apb(1'b0, {IDX[i], 2'b00}, $urandom, {1'b0, mon[i]});
  endtask

  // expected status word: update count, freeze bit, missed bit
  function automatic logic [DATA_W-1:0] stat(input int c, input logic f, input logic m);
    stat = '0;
    stat[STAT_COUNT_LSB +: COUNT_W] = COUNT_W'(c);
    stat[STAT_FREEZE_BIT]           = f;
    stat[STAT_MISSED_BIT]           = m;
  endfunction

  task automatic upd(input int n, input logic take);
    logic [DATA_W-1:0] v;
    repeat (n) begin
      foreach (vin[i]) begin
        v = $urandom;
        vin[i] <= v;
        if (take) mon[i] = v;
      end
      update <= 1'b1;
      @(posedge clk);
    end
    update <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (resetn && psel && penable && pready) begin
      got = {pslverr, prdata};
      want = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      checked++;
      if (got !== want) begin
        $display("ERROR at %0t: expected %h got %h", $time, want, got);
        num_errors++;
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #500_000;
    num_errors++;
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    update = 1'b0;
    paddr = '0;
    pwdata = '0;
    foreach (vin[i]) vin[i] = '0;
    foreach (mon[i]) mon[i] = MONITOR_RESET;
    void'($urandom(21));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd_all();
    upd(1, 1'b1);
    rd_all();
    foreach (IDX[i]) apb(1'b1, {IDX[i], 2'b00}, $urandom, {1'b1, 32'h0});
    rd_all();
    upd(3, 1'b1);
    rd_all();
    apb(1'b0, 16'h1340, $urandom, {1'b1, UNMAPPED_READ});
    apb(1'b1, 16'h12e2, $urandom, {1'b1, 32'h0});
    apb(1'b0, 16'h12e1, $urandom, {1'b1, UNMAPPED_READ});
    apb(1'b1, {MONITOR_CONTROL_IDX, 2'b00}, 32'h1, 33'h0);
    upd(1, 1'b0);
    rd_all();
    apb(1'b0, {MONITOR_CONTROL_IDX, 2'b00}, $urandom, {1'b0, 32'h1});
    apb(1'b0, {MONITOR_STATUS_IDX, 2'b00}, $urandom, {1'b0, stat(4, 1'b1, 1'b1)});
    apb(1'b1, {MONITOR_STATUS_IDX, 2'b00}, 32'h1 << STAT_MISSED_BIT, 33'h0);
    apb(1'b0, {MONITOR_STATUS_IDX, 2'b00}, $urandom, {1'b0, stat(4, 1'b1, 1'b0)});
    apb(1'b1, {MONITOR_CONTROL_IDX, 2'b00}, 32'h0, 33'h0);
    upd(2, 1'b1);
    apb(1'b0, {MONITOR_STATUS_IDX, 2'b00}, $urandom, {1'b0, stat(6, 1'b0, 1'b0)});
    resetn <= 1'b0;
    foreach (mon[i]) mon[i] = MONITOR_RESET;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd_all();
    apb(1'b0, {MONITOR_STATUS_IDX, 2'b00}, $urandom, {1'b0, stat(0, 1'b0, 1'b0)});
    finish_test();
  end
endmodule
